// [rtl/gas_styler.sv]
// glyph row styler: register port, row transform and readback
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE1: scanline, control, bitmap, attribute registers held
// RULE2: three side pins steer the transform
// RULE3: host writes with oe high, we low
// RULE4: oe low, we high: device drives data
// RULE5: dedicated outputs always show readback
// RULE6: address 0: physical in, logical out
// RULE7: addresses 2,3: source in, transformed out
// RULE8: control bits 0-3 steer the cursor
// RULE9: control bits 4,5 permit decoration, blink
// RULE10: address 4 low bits: double size, half
// RULE11: address 4 high bits: mirroring
// RULE12: address 5: text style attributes
// RULE13: addresses 6,7: line decorations
// RULE14: faint polarity picks suppressed pixels
// RULE15: host order: scanline, read, row, read
// RULE16: writes on clock edge, readback from regs
// RULE17: oe high releases the data pins
module gas_styler (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic reg_select_bit0,
  input wire logic reg_select_bit1,
  input wire logic reg_select_bit2,
  input wire logic faint_pol,
  input wire logic blink_phase,
  input wire logic cursor_pin_en,
  input wire logic oe_b,
  input wire logic we_b,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe,
  output logic [7:0] result_out
);
  //////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  gas_pkg::gas_pins_t pins_raw;
  gas_pkg::gas_pins_t pins_s;
  logic [7:0] din_s;

  assign pins_raw = '{sel: {reg_select_bit2, reg_select_bit1,
                            reg_select_bit0},
                      faint_pol: faint_pol,
                      blink_phase: blink_phase,
                      curs_pin: cursor_pin_en,
                      oe_b: oe_b,
                      we_b: we_b};

  gas_sync #(.W($bits(gas_pkg::gas_pins_t))) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  gas_sync #(.W(8)) u_data_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in(data_in),
    .sync_out(din_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // register file
  logic [3:0] scan_q;
  gas_pkg::gas_ctrl_t ctrl_q;
  logic [15:0] row_q;
  gas_pkg::gas_geom_t geom_q;
  gas_pkg::gas_style_t style_q;
  gas_pkg::gas_deco_t deco_q;
  logic dot_over_q;
  logic wr_en;

  // a write is taken every enabled edge the strobes stay in write state
  assign wr_en = pins_s.oe_b && !pins_s.we_b; // RULE3

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_q <= gas_pkg::RST_SCAN;
    end else if (clk_en && wr_en && pins_s.sel == gas_pkg::ADDR_SCAN) begin
      scan_q <= din_s[3:0]; // RULE6 RULE16
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= gas_pkg::RST_BYTE;
    end else if (clk_en && wr_en && pins_s.sel == gas_pkg::ADDR_CTRL) begin
      ctrl_q <= din_s; // RULE1
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      row_q <= gas_pkg::RST_ROW;
    end else if (clk_en && wr_en) begin
      if (pins_s.sel == gas_pkg::ADDR_ROWR) begin
        row_q[7:0] <= din_s; // RULE7
      end else if (pins_s.sel == gas_pkg::ADDR_ROWL) begin
        row_q[15:8] <= din_s; // RULE7
      end
    end
  end

  // attribute register: 8 + 8 + 8 + 1 bits
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      geom_q <= gas_pkg::RST_BYTE;
      style_q <= gas_pkg::RST_BYTE;
      deco_q <= gas_pkg::RST_BYTE;
      dot_over_q <= 1'b0;
    end else if (clk_en && wr_en) begin
      case (pins_s.sel)
        gas_pkg::ADDR_GEOM: geom_q <= din_s; // RULE10 RULE11
        gas_pkg::ADDR_STYLE: style_q <= din_s; // RULE12
        gas_pkg::ADDR_DECO: deco_q <= din_s; // RULE13
        gas_pkg::ADDR_XDECO: dot_over_q <= din_s[0]; // RULE13
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transform helpers
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction

  // solid, doubled or dotted line on the given row(s)
  function automatic logic [15:0] line_pat(
    input logic [3:0] l, input logic [3:0] at,
    input logic [3:0] at_a, input logic [3:0] at_b,
    input logic one, input logic two, input logic dot
  );
    logic [15:0] p;
    p = '0;
    if (one && l == at) begin
      p = gas_pkg::ROW_FULL;
    end
    if (two && (l == at_a || l == at_b)) begin
      p = gas_pkg::ROW_FULL;
    end
    if (dot && l == at) begin
      p = p | gas_pkg::DOT_PAT;
    end
    return p;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // logical scanline
  logic [3:0] phys;
  logic [3:0] logic_scan;

  always_comb begin
    phys = scan_q ^ {4{geom_q.y_pre}}; // RULE11
    if (geom_q.dbl_h) begin
      logic_scan = {geom_q.y_half, phys[3:1]}; // RULE10
    end else begin
      logic_scan = phys;
    end
    logic_scan = logic_scan ^ {4{geom_q.y_post}}; // RULE11
  end

  //////////////////////////////////////////////////////////////////////////
  // glyph row transform
  logic [15:0] src_row;
  logic [7:0] half_row;
  logic [15:0] wide_row;
  logic [15:0] shaped_row;
  logic [15:0] faint_mask;
  logic [15:0] deco_row;
  logic [15:0] curs_row;
  logic [15:0] fin_row;
  logic blink_off;
  logic alt_on;
  logic curs_vis;

  // RULE11
  assign src_row = geom_q.x_pre ? rev16(row_q) : row_q;
  // x_half low shows the left half
  assign half_row = geom_q.x_half ? src_row[7:0] : src_row[15:8]; // RULE10

  for (genvar g = 0; g < 8; g++) begin : g_widen
    assign wide_row[2*g+1:2*g] = {2{half_row[g]}}; // RULE10
  end

  // faint drops even pixels when the pin is low, odd ones when high
  assign faint_mask = pins_s.faint_pol ? gas_pkg::ODD_PIX
                                       : gas_pkg::EVEN_PIX; // RULE14 RULE2

  always_comb begin
    shaped_row = geom_q.dbl_w ? wide_row : src_row;
    if (style_q.bold) begin
      shaped_row = shaped_row | (shaped_row >> 1); // RULE12
    end
    // upper half leans right, lower half stays put
    if (style_q.italic && logic_scan < gas_pkg::ROW_HALF) begin
      shaped_row = shaped_row >> 1; // RULE12
    end
    if (style_q.rev_italic && logic_scan < gas_pkg::ROW_HALF) begin
      shaped_row = shaped_row << 1; // RULE12
    end
    if (style_q.faint) begin
      shaped_row = shaped_row & ~faint_mask; // RULE14
    end
  end

  always_comb begin
    deco_row = '0;
    if (ctrl_q.line_en) begin // RULE9
      deco_row = line_pat(logic_scan, gas_pkg::ROW_BOT,
                          gas_pkg::ROW_BOT2, gas_pkg::ROW_BOT,
                          deco_q.under, deco_q.dbl_under,
                          deco_q.dot_under) // RULE13
               | line_pat(logic_scan, gas_pkg::ROW_MID,
                          gas_pkg::ROW_MID_HI, gas_pkg::ROW_MID_LO,
                          deco_q.strike, deco_q.dbl_strike,
                          deco_q.dot_strike) // RULE13
               | line_pat(logic_scan, gas_pkg::ROW_TOP,
                          gas_pkg::ROW_TOP, gas_pkg::ROW_TOP2,
                          deco_q.over, deco_q.dbl_over,
                          dot_over_q); // RULE13
    end
  end

  // blink and alternate act during the high blink phase only
  assign blink_off = ctrl_q.alt_en && style_q.blink
                     && pins_s.blink_phase; // RULE9 RULE2
  assign alt_on = ctrl_q.alt_en && style_q.alternate
                  && pins_s.blink_phase; // RULE9 RULE2
  assign curs_vis = ctrl_q.curs_on && pins_s.curs_pin
                    && (!ctrl_q.curs_blink || pins_s.blink_phase); // RULE8

  always_comb begin
    curs_row = '0;
    if (curs_vis) begin
      if (ctrl_q.curs_top && logic_scan <= gas_pkg::CURS_TOP_END) begin
        curs_row = gas_pkg::ROW_FULL; // RULE8
      end
      if (ctrl_q.curs_bot && logic_scan >= gas_pkg::CURS_BOT_BEG) begin
        curs_row = gas_pkg::ROW_FULL; // RULE8
      end
    end
  end

  always_comb begin
    fin_row = shaped_row | deco_row;
    if (style_q.hidden || blink_off) begin
      fin_row = '0; // RULE12
    end
    if (style_q.inverse ^ alt_on) begin
      fin_row = ~fin_row; // RULE12
    end
    // cursor is XORed over everything, so it stays visible on inverse
    fin_row = fin_row ^ curs_row;
    if (geom_q.x_post) begin
      fin_row = rev16(fin_row); // RULE11
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // readback
  logic [7:0] rd_val;

  always_comb begin
    case (pins_s.sel)
      gas_pkg::ADDR_SCAN: rd_val = {4'h0, logic_scan}; // RULE6
      gas_pkg::ADDR_CTRL: rd_val = ctrl_q;
      gas_pkg::ADDR_ROWR: rd_val = fin_row[7:0]; // RULE7
      gas_pkg::ADDR_ROWL: rd_val = fin_row[15:8]; // RULE7
      gas_pkg::ADDR_GEOM: rd_val = geom_q;
      gas_pkg::ADDR_STYLE: rd_val = style_q;
      gas_pkg::ADDR_DECO: rd_val = deco_q;
      gas_pkg::ADDR_XDECO: rd_val = {7'h00, dot_over_q}; // RULE13
      default: rd_val = gas_pkg::RST_BYTE;
    endcase
  end

  // readback is registered once so every output leaves a flip-flop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out <= gas_pkg::RST_BYTE;
      result_out <= gas_pkg::RST_BYTE;
    end else if (clk_en) begin
      data_out <= rd_val; // RULE4 RULE16
      result_out <= rd_val; // RULE5
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_oe <= 8'h00;
    end else if (clk_en) begin
      data_oe <= {8{!pins_s.oe_b && pins_s.we_b}}; // RULE4 RULE17
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_scan_wr;
    clk_en && wr_en && pins_s.sel == gas_pkg::ADDR_SCAN
      |=> scan_q == $past(din_s[3:0]);
  endproperty
  a_scan_wr: assert property (p_scan_wr) // RULE6
    else $error("scanline write not stored");
  property p_scan_hi;
    clk_en && pins_s.sel == gas_pkg::ADDR_SCAN |=> result_out[7:4] == 4'h0;
  endproperty
  a_scan_hi: assert property (p_scan_hi) // RULE6
    else $error("scanline upper bits not zero");
  property p_xdeco_hi;
    clk_en && pins_s.sel == gas_pkg::ADDR_XDECO |=> result_out[7:1] == 7'h00;
  endproperty
  a_xdeco_hi: assert property (p_xdeco_hi) // RULE13
    else $error("address 7 upper bits not zero");
  property p_release;
    clk_en && pins_s.oe_b |=> data_oe == 8'h00;
  endproperty
  a_release: assert property (p_release) // RULE17
    else $error("data pins driven while oe high");
  property p_drive;
    clk_en && !pins_s.oe_b && pins_s.we_b |=> data_oe == 8'hff;
  endproperty
  a_drive: assert property (p_drive) // RULE4
    else $error("data pins not driven on read");
  // stored geometry must reach the dedicated pins with no strobe involved
  property p_dedicated;
    clk_en && pins_s.sel == gas_pkg::ADDR_GEOM
      |=> result_out == $past(geom_q);
  endproperty
  a_dedicated: assert property (p_dedicated) // RULE5
    else $error("dedicated outputs differ from readback");
  property p_ctrl_wr;
    clk_en && wr_en && pins_s.sel == gas_pkg::ADDR_CTRL
      ##1 clk_en && !wr_en && pins_s.sel == gas_pkg::ADDR_CTRL
      |=> result_out == $past(din_s, 2);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) // RULE8
    else $error("control readback wrong");
  property p_hidden;
    style_q.hidden && !style_q.inverse && !alt_on && !curs_vis
      |-> fin_row == 16'h0000;
  endproperty
  a_hidden: assert property (p_hidden) // RULE12
    else $error("hidden row not blank");
  // checked on the final row, with the pin mapped to its mask afresh
  property p_faint;
    style_q.faint && !(style_q.inverse ^ alt_on) && !geom_q.x_post
      && deco_row == 16'h0000 && curs_row == 16'h0000
      |-> (fin_row & (pins_s.faint_pol ? gas_pkg::ODD_PIX
                                       : gas_pkg::EVEN_PIX)) == 16'h0000;
  endproperty
  a_faint: assert property (p_faint) // RULE14
    else $error("faint pixels not suppressed");
  property p_logical;
    !geom_q.dbl_h && !geom_q.y_pre && !geom_q.y_post
      |-> logic_scan == scan_q;
  endproperty
  a_logical: assert property (p_logical) // RULE11
    else $error("logical scanline differs");
  c_row_write: cover property (wr_en && pins_s.sel == gas_pkg::ADDR_ROWL);
  c_read: cover property (!pins_s.oe_b && pins_s.we_b);
  c_cursor: cover property (curs_vis && curs_row != 16'h0000);
  c_deco: cover property (deco_row != 16'h0000);
endmodule // gas_styler

// [rtl/gas_pkg.sv]
// shared constants and carrier types of the glyph attribute styler
package gas_pkg;
  localparam logic [2:0] ADDR_SCAN = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_ROWR = 3'h2;
  localparam logic [2:0] ADDR_ROWL = 3'h3;
  localparam logic [2:0] ADDR_GEOM = 3'h4;
  localparam logic [2:0] ADDR_STYLE = 3'h5;
  localparam logic [2:0] ADDR_DECO = 3'h6;
  localparam logic [2:0] ADDR_XDECO = 3'h7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_SCAN = 4'h0;
  localparam logic [15:0] RST_ROW = 16'h0000;
  localparam logic [3:0] ROW_TOP = 4'h0;
  localparam logic [3:0] ROW_TOP2 = 4'h2;
  localparam logic [3:0] ROW_MID = 4'h7;
  localparam logic [3:0] ROW_MID_HI = 4'h6;
  localparam logic [3:0] ROW_MID_LO = 4'h8;
  localparam logic [3:0] ROW_BOT = 4'hf;
  localparam logic [3:0] ROW_BOT2 = 4'hd;
  localparam logic [3:0] ROW_HALF = 4'h8;
  localparam logic [3:0] CURS_TOP_END = 4'h1;
  localparam logic [3:0] CURS_BOT_BEG = 4'he;
  localparam logic [15:0] DOT_PAT = 16'haaaa;
  localparam logic [15:0] EVEN_PIX = 16'h5555;
  localparam logic [15:0] ODD_PIX = 16'haaaa;
  localparam logic [15:0] ROW_FULL = 16'hffff;

  typedef struct packed {
    logic rsvd7;
    logic rsvd6;
    logic alt_en;
    logic line_en;
    logic curs_on;
    logic curs_blink;
    logic curs_top;
    logic curs_bot;
  } gas_ctrl_t;

  typedef struct packed {
    logic y_post;
    logic y_pre;
    logic x_post;
    logic x_pre;
    logic dbl_h;
    logic y_half;
    logic dbl_w;
    logic x_half;
  } gas_geom_t;

  typedef struct packed {
    logic hidden;
    logic inverse;
    logic alternate;
    logic blink;
    logic rev_italic;
    logic italic;
    logic faint;
    logic bold;
  } gas_style_t;

  typedef struct packed {
    logic dbl_over;
    logic over;
    logic dot_strike;
    logic dbl_strike;
    logic strike;
    logic dot_under;
    logic dbl_under;
    logic under;
  } gas_deco_t;

  typedef struct packed {
    logic [2:0] sel;
    logic faint_pol;
    logic blink_phase;
    logic curs_pin;
    logic oe_b;
    logic we_b;
  } gas_pins_t;
endpackage

// [rtl/gas_sync.sv]
// two-stage synchroniser for asynchronous pin inputs
module gas_sync #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // refused while elaborating: a zero-width synchroniser carries nothing
  if (W < 1) begin : g_bad_w
    $error("gas_sync width must be at least one");
  end

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // gas_sync

// [verification/gas_host_model.sv]
// host model: the video controller driving the styler's parallel port
module gas_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  output logic [2:0] sel,
  output logic oe_b,
  output logic we_b,
  output logic [7:0] pin_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_en = 1'b0;
  logic [7:0] host_d = 8'h00;
  logic [7:0] last_q = 8'h00;
  initial begin
    sel = 3'h0;
    oe_b = 1'b1;
    we_b = 1'b1;
  end
  // an undriven pin keeps changing, so a stale value can never pass
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_bus[i] = data_oe[i] ? data_out[i] : host_en ? host_d[i] :
        ~last_q[i];
    end
  end
  always @(posedge ref_clk) begin
    last_q <= pin_bus;
  end
  //////////////////////////////////////////////////////////////////////////
  // strobes held 5 cycles: pins pass two sync flops before capture
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sel = a;
    host_d = d;
    host_en = 1'b1;
    oe_b = 1'b1;
    we_b = 1'b0;
    repeat (5) @(negedge ref_clk);
    we_b = 1'b1;
    host_en = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d,
                    output logic [7:0] en);
    @(negedge ref_clk);
    sel = a;
    oe_b = 1'b0;
    we_b = 1'b1;
    repeat (5) @(negedge ref_clk);
    d = pin_bus;
    en = data_oe;
    oe_b = 1'b1;
    // turnaround: the device must let go before the host drives again
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic clash(input logic [2:0] a, input logic [7:0] d,
                       output logic [7:0] en);
    @(negedge ref_clk);
    sel = a;
    host_d = d;
    host_en = 1'b1;
    oe_b = 1'b0;
    we_b = 1'b0;
    repeat (5) @(negedge ref_clk);
    en = data_oe;
    oe_b = 1'b1;
    we_b = 1'b1;
    host_en = 1'b0;
  endtask
endmodule // gas_host_model

// [verification/tb.sv]
// self-checking bench of the glyph attribute styler
`define CHK(what, exp, got) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("mismatch %s exp %h got %h", what, exp, got); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic faint_pol = 1'b0;
  logic blink_phase = 1'b0;
  logic cursor_pin_en = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] sel;
  logic oe_b;
  logic we_b;
  logic [7:0] pin_bus;
  logic [7:0] data_out;
  logic [7:0] data_oe;
  logic [7:0] result_out;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  // {ctrl, style, faint_pol, blink_phase, row}
  logic [39:0] sty [11] = '{40'h00_01_0_0_c18f, 40'h00_02_0_0_800a,
    40'h00_02_1_0_0105, 40'h00_04_0_0_4087, 40'h00_08_0_0_021e,
    40'h20_10_0_1_0000, 40'h20_10_0_0_810f, 40'h00_10_0_1_810f,
    40'h20_20_0_1_7ef0, 40'h00_40_0_0_7ef0, 40'h00_80_0_0_0000};
  // {ctrl, deco, xdeco, scan, row}
  logic [39:0] dec [11] = '{40'h10_01_0_f_ffff, 40'h10_01_0_e_0000,
    40'h00_01_0_f_0000, 40'h10_02_0_d_ffff, 40'h10_04_0_f_aaaa,
    40'h10_08_0_7_ffff, 40'h10_10_0_6_ffff, 40'h10_20_0_7_aaaa,
    40'h10_40_0_0_ffff, 40'h10_80_0_2_ffff, 40'h10_00_1_0_aaaa};
  // {ctrl, pin, phase, scan, row}
  logic [35:0] cur [7] = '{36'h09_1_0_f_ffff, 36'h09_1_0_1_0000,
    36'h0a_1_0_1_ffff, 36'h0a_0_0_1_0000, 36'h0e_1_0_1_0000,
    36'h0e_1_1_1_ffff, 36'h02_1_0_1_0000};
  // {geom, scan, logical}
  logic [15:0] geo [5] = '{16'h40_3_c, 16'hc0_3_3, 16'h08_6_3,
    16'h0c_6_b, 16'h80_2_d};
  // {geom, row}
  logic [23:0] grw [4] = '{24'h10_f081, 24'h20_f081, 24'h02_c003,
    24'h03_00ff};
  logic [7:0] en;

  always #2.5 ref_clk = ~ref_clk;

  gas_styler dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .reg_select_bit0(sel[0]),
    .reg_select_bit1(sel[1]),
    .reg_select_bit2(sel[2]),
    .faint_pol(faint_pol),
    .blink_phase(blink_phase),
    .cursor_pin_en(cursor_pin_en),
    .oe_b(oe_b),
    .we_b(we_b),
    .data_in(pin_bus),
    .data_out(data_out),
    .data_oe(data_oe),
    .result_out(result_out)
  );

  gas_host_model host (
    .ref_clk(ref_clk),
    .data_out(data_out),
    .data_oe(data_oe),
    .sel(sel),
    .oe_b(oe_b),
    .we_b(we_b),
    .pin_bus(pin_bus)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // dedicated outputs show the readback with no read strobe at all
  task automatic wrc(input logic [2:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    host.wr(a, d);
    `CHK("result_out", e, result_out)
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    logic [7:0] oe;
    host.rd(a, v, oe);
    `CHK("data pins", e, v)
    `CHK("data_oe read", 8'hff, oe)
    `CHK("result_out", e, result_out)
  endtask
  task automatic chkrow(input logic [15:0] e);
    rdc(gas_pkg::ADDR_ROWR, e[7:0]);
    rdc(gas_pkg::ADDR_ROWL, e[15:8]);
  endtask
  task automatic side(input logic f, input logic b, input logic c);
    @(negedge ref_clk);
    faint_pol = f;
    blink_phase = b;
    cursor_pin_en = c;
  endtask

  // generous: the whole sequence needs under 3000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK("data_oe idle", 8'h00, data_oe)
    for (int i = 0; i < 8; i++) begin
      rdc(3'(i), 8'h00);
    end
    wrc(gas_pkg::ADDR_SCAN, 8'hff, 8'h0f);
    rdc(gas_pkg::ADDR_SCAN, 8'h0f);
    for (int i = 0; i < 5; i++) begin
      wrc(gas_pkg::ADDR_GEOM, geo[i][15:8], geo[i][15:8]);
      wrc(gas_pkg::ADDR_SCAN, {4'h0, geo[i][7:4]}, {4'h0, geo[i][3:0]});
    end
    rdc(gas_pkg::ADDR_SCAN, 8'h0d);
    wrc(gas_pkg::ADDR_GEOM, 8'h00, 8'h00);
    wrc(gas_pkg::ADDR_SCAN, 8'h05, 8'h05);
    rdc(gas_pkg::ADDR_SCAN, 8'h05);
    wrc(gas_pkg::ADDR_ROWR, 8'h0f, 8'h0f);
    wrc(gas_pkg::ADDR_ROWL, 8'h81, 8'h81);
    chkrow(16'h810f);
    for (int i = 0; i < 11; i++) begin
      side(sty[i][20], sty[i][16], 1'b0);
      wrc(gas_pkg::ADDR_CTRL, sty[i][39:32], sty[i][39:32]);
      wrc(gas_pkg::ADDR_STYLE, sty[i][31:24], sty[i][31:24]);
      chkrow(sty[i][15:0]);
    end
    wrc(gas_pkg::ADDR_STYLE, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wrc(gas_pkg::ADDR_GEOM, grw[i][23:16], grw[i][23:16]);
      chkrow(grw[i][15:0]);
    end
    wrc(gas_pkg::ADDR_GEOM, 8'h00, 8'h00);
    wrc(gas_pkg::ADDR_ROWR, 8'h00, 8'h00);
    wrc(gas_pkg::ADDR_ROWL, 8'h00, 8'h00);
    for (int i = 0; i < 11; i++) begin
      wrc(gas_pkg::ADDR_CTRL, dec[i][39:32], dec[i][39:32]);
      wrc(gas_pkg::ADDR_DECO, dec[i][31:24], dec[i][31:24]);
      wrc(gas_pkg::ADDR_XDECO, {4'h0, dec[i][23:20]}, {4'h0, dec[i][23:20]});
      wrc(gas_pkg::ADDR_SCAN, {4'h0, dec[i][19:16]}, {4'h0, dec[i][19:16]});
      chkrow(dec[i][15:0]);
    end
    wrc(gas_pkg::ADDR_DECO, 8'h00, 8'h00);
    wrc(gas_pkg::ADDR_XDECO, 8'h00, 8'h00);
    for (int i = 0; i < 7; i++) begin
      side(1'b0, cur[i][20], cur[i][24]);
      wrc(gas_pkg::ADDR_CTRL, cur[i][35:28], cur[i][35:28]);
      wrc(gas_pkg::ADDR_SCAN, {4'h0, cur[i][19:16]}, {4'h0, cur[i][19:16]});
      chkrow(cur[i][15:0]);
    end
    wrc(gas_pkg::ADDR_XDECO, 8'hff, 8'h01);
    wrc(gas_pkg::ADDR_CTRL, 8'hff, 8'hff);
    host.clash(gas_pkg::ADDR_CTRL, 8'h00, en);
    `CHK("data_oe both low", 8'h00, en)
    rdc(gas_pkg::ADDR_CTRL, 8'hff);
    // a write made while the clock enable is low must leave no trace
    clk_en = 1'b0;
    host.wr(gas_pkg::ADDR_CTRL, 8'h00);
    clk_en = 1'b1;
    rdc(gas_pkg::ADDR_CTRL, 8'hff);
    `CHK("data_oe released", 8'h00, data_oe)
    tally_and_finish();
  end
endmodule // tb
